//--- rtl/brpw_core.sv
`timescale 1ns/10ps
// Posted-write fault reporting and bus-reset handling for async contexts
module brpw_core
    import brpw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    input wire logic physReadDone,
    input wire logic physReadHostErr,
    input wire logic respAckValid,
    input wire logic [3:0] respAckCode,
    input wire logic retryHostErr,
    output logic respSend,
    output logic [3:0] respCode,
    output logic respRetired,
    input wire logic writeReq,
    input wire logic writePostable,
    output logic writeAckValid,
    output logic [3:0] writeAckCode,
    input wire logic postDone,
    input wire logic postFail,
    input wire logic [15:0] postSrcNode,
    input wire logic [47:0] postOffset,
    output logic pendingDiscard,
    input wire logic busResetDetect,
    input wire logic [7:0] newGeneration,
    input wire logic atSentAwaitAck,
    input wire logic atQueued,
    input wire logic [1:0] atRun,
    input wire logic [1:0] atQuiet,
    output logic atHalt,
    output logic atFlush,
    output logic atStatusValid,
    output logic [4:0] atStatusCode,
    output logic [1:0] atActive,
    input wire logic arReqActive,
    input wire logic rxFifoSpace,
    input wire logic hostBufSpace,
    input wire logic rxPacketSeen,
    input wire logic rqPacketDelivered,
    output logic brPktWrite,
    output logic [4:0] brPktEvent,
    output logic [7:0] brPktGeneration,
    output logic isoHold
);
    logic [31:0] interrupt_event_reg, next_interrupt_event_reg;
    logic [2:0] pendCount, next_pendCount;
    logic [2:0] qCount;
    logic [BRPW_FAULT_W-1:0] faultHead;
    logic qNotEmpty, faultClear, qPop, reportFlag;
    logic nextAckValid;
    logic [3:0] nextAckCode;
    brpw_at_e atState, next_atState;
    logic next_atStatusValid;
    logic [4:0] next_atStatusCode;
    logic [1:0] next_atActive;
    logic brPend, next_brPend, next_brPktWrite;
    logic [7:0] brGen, next_brGen;
    logic [31:0] next_regRdata;
    logic next_pendingDiscard;
    // Bus-reset packet slots and registered status next values
    logic brHeld, next_brHeld, brSeen, next_brSeen, brSendNow;
    logic [7:0] brHeldGen, next_brHeldGen, next_brPktGen;
    logic next_atHalt, next_atFlush, next_isoHold;
    logic [4:0] next_brPktEvent;

    // Read response path
    brpw_resp_retry respUnit (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .readDone(physReadDone),
        .readHostErr(physReadHostErr),
        .ackValid(respAckValid),
        .ackCode(respAckCode),
        .retryHostErr(retryHostErr),
        .discard(busResetDetect),
        .respSend(respSend),
        .respCode(respCode),
        .respRetired(respRetired)
    );

    // Failed posted writes waiting to be reported, oldest first
    brpw_fault_queue faultQ (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .push(postFail),
        .pushData({postSrcNode, postOffset}),
        .pop(qPop),
        .flush(busResetDetect),
        .headData(faultHead),
        .notEmpty(qNotEmpty),
        .count(qCount)
    );

    // Register write strobe aimed at one offset
    function automatic logic wrHit(input logic wr, input logic [7:0] addr,
        input logic [7:0] ofs);
        return wr && (addr == ofs);
    endfunction

    assign faultClear = wrHit(regWrite, regAddr, BRPW_OFS_INT_CLR)
        && regWdata[BRPW_BIT_PWFAULT];
    // Pop only while a fault is shown; a bus reset may have emptied the queue
    assign qPop = faultClear && interrupt_event_reg[BRPW_BIT_PWFAULT] && qNotEmpty;
    assign reportFlag = qNotEmpty && !qPop;

    // Posting decision and pending count
    always_comb begin
        nextAckValid = writeReq;
        nextAckCode = BRPW_ACK_PENDING;
        next_pendCount = pendCount;
        if (writeReq && writePostable && pendCount < 3'(BRPW_PEND_MAX)) begin
            nextAckCode = BRPW_ACK_COMPLETE;
            next_pendCount = next_pendCount + 3'h1;
        end
        if (postDone && next_pendCount != 3'h0) begin
            next_pendCount = next_pendCount - 3'h1;
        end
        if (qPop && next_pendCount != 3'h0) begin
            next_pendCount = next_pendCount - 3'h1;
        end
        if (busResetDetect) begin
            next_pendCount = 3'h0;
        end
        next_pendingDiscard = busResetDetect;
    end

    // Interrupt event register: hardware event sets win over a clear
    always_comb begin
        next_interrupt_event_reg = interrupt_event_reg;
        if (wrHit(regWrite, regAddr, BRPW_OFS_INT_SET)) begin
            next_interrupt_event_reg = next_interrupt_event_reg | regWdata;
        end
        if (wrHit(regWrite, regAddr, BRPW_OFS_INT_CLR)) begin
            next_interrupt_event_reg = next_interrupt_event_reg & ~regWdata;
        end
        next_interrupt_event_reg[BRPW_BIT_PWFAULT] = (interrupt_event_reg[BRPW_BIT_PWFAULT] && !faultClear)
            || reportFlag || postFail;
        if (busResetDetect) begin
            next_interrupt_event_reg[BRPW_BIT_BUSRST] = 1'b1;
        end
        if (rqPacketDelivered || brPktWrite) begin
            next_interrupt_event_reg[BRPW_BIT_REQUEST_PACKET_EVENT] = 1'b1;
        end
    end

    // Async transmit flush sequencing
    always_comb begin
        next_atState = atState;
        next_atStatusValid = 1'b0;
        next_atStatusCode = atStatusCode;
        next_atActive = atActive;
        for (int i = 0; i < 2; i++) begin
            if (atRun[i]) begin
                next_atActive[i] = 1'b1;
            end
        end
        unique case (atState)
            BRPW_AT_IDLE: begin
                if (busResetDetect) begin
                    next_atState = BRPW_AT_FLUSH;
                end
            end
            BRPW_AT_FLUSH: begin
                next_atStatusValid = atSentAwaitAck || atQueued;
                next_atStatusCode = atSentAwaitAck ? BRPW_EVT_MISSING_ACK
                    : BRPW_EVT_FLUSHED;
                if (!atSentAwaitAck && !atQueued) begin
                    next_atState = BRPW_AT_DRAIN;
                end
            end
            BRPW_AT_DRAIN: begin
                for (int i = 0; i < 2; i++) begin
                    if (atQuiet[i]) begin
                        next_atActive[i] = 1'b0;
                    end
                end
                if (!next_interrupt_event_reg[BRPW_BIT_BUSRST]) begin
                    next_atState = BRPW_AT_IDLE;
                end
            end
            default: next_atState = BRPW_AT_IDLE;
        endcase
    end

    // Synthesized bus-reset packets: a head slot and one held behind it
    // Only two deep: a third reset after a packet gap merges into the held slot
    always_comb begin
        next_brPend = brPend;
        next_brGen = brGen;
        next_brHeld = brHeld;
        next_brHeldGen = brHeldGen;
        next_brSeen = brSeen || rxPacketSeen;
        next_brPktWrite = 1'b0;
        next_brPktGen = brPktGeneration;
        brSendNow = brPend && rxFifoSpace && hostBufSpace;
        if (brSendNow) begin
            next_brPend = brHeld;
            next_brGen = brHeldGen;
            next_brHeld = 1'b0;
            next_brPktWrite = 1'b1;
            next_brPktGen = brGen;
        end
        // A send and a new reset may share a cycle
        if (busResetDetect && arReqActive) begin
            next_brSeen = 1'b0;
            if (!next_brPend) begin
                next_brPend = 1'b1;
                next_brGen = newGeneration;
            end else if (next_brHeld) begin
                next_brHeldGen = newGeneration;
            end else if (brSeen || rxPacketSeen) begin
                next_brHeld = 1'b1;
                next_brHeldGen = newGeneration;
            end else begin
                next_brGen = newGeneration;
            end
        end
    end

    // Register read mux
    always_comb begin
        next_regRdata = 32'h0;
        if (regRead) begin
            unique case (regAddr)
                BRPW_OFS_FAULT_LO: next_regRdata = faultHead[31:0];
                BRPW_OFS_FAULT_HI: next_regRdata = faultHead[63:32];
                BRPW_OFS_INT_SET, BRPW_OFS_INT_CLR: next_regRdata = interrupt_event_reg;
                default: next_regRdata = 32'h0;
            endcase
        end
    end

    // State registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            interrupt_event_reg <= BRPW_INT_RESET;
            pendCount <= 3'h0;
            writeAckValid <= 1'b0;
            writeAckCode <= BRPW_ACK_COMPLETE;
            pendingDiscard <= 1'b0;
            atState <= BRPW_AT_IDLE;
            atStatusValid <= 1'b0;
            atStatusCode <= BRPW_EVT_FLUSHED;
            atActive <= 2'h0;
            brPend <= 1'b0;
            brGen <= 8'h0;
            brHeld <= 1'b0;
            brHeldGen <= 8'h0;
            brSeen <= 1'b0;
            brPktWrite <= 1'b0;
            regRdata <= 32'h0;
        end else begin
            interrupt_event_reg <= next_interrupt_event_reg;
            pendCount <= next_pendCount;
            writeAckValid <= nextAckValid;
            writeAckCode <= nextAckCode;
            pendingDiscard <= next_pendingDiscard;
            atState <= next_atState;
            atStatusValid <= next_atStatusValid;
            atStatusCode <= next_atStatusCode;
            atActive <= next_atActive;
            brPend <= next_brPend;
            brGen <= next_brGen;
            brHeld <= next_brHeld;
            brHeldGen <= next_brHeldGen;
            brSeen <= next_brSeen;
            brPktWrite <= next_brPktWrite;
            regRdata <= next_regRdata;
        end
    end

    // Halt and flush follow the transmit state; isochronous left running
    always_comb begin
        next_atHalt = (next_atState != BRPW_AT_IDLE);
        next_atFlush = (next_atState != BRPW_AT_IDLE);
        next_brPktEvent = BRPW_EVT_BUS_RESET;
        next_isoHold = 1'b0;
    end

    // Registered status outputs; isochronous contexts never held
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            atHalt <= 1'b0;
            atFlush <= 1'b0;
            brPktEvent <= BRPW_EVT_BUS_RESET;
            brPktGeneration <= 8'h0;
            isoHold <= 1'b0;
        end else begin
            atHalt <= next_atHalt;
            atFlush <= next_atFlush;
            brPktEvent <= next_brPktEvent;
            brPktGeneration <= next_brPktGen;
            isoHold <= next_isoHold;
        end
    end
endmodule // brpw_core

//--- rtl/brpw_fault_queue.sv
`timescale 1ns/10ps
// Four-entry in-order store of failed posted-write addresses
module brpw_fault_queue
    import brpw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic push,
    input wire logic [BRPW_FAULT_W-1:0] pushData,
    input wire logic pop,
    input wire logic flush,
    output logic [BRPW_FAULT_W-1:0] headData,
    output logic notEmpty,
    output logic [2:0] count
);
    logic [BRPW_FAULT_W-1:0] mem [0:3];
    logic [1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [2:0] next_count;
    logic doPush, doPop;

    // Pointer and occupancy update, push and pop may coincide
    always_comb begin
        doPush = push && (count < 3'(BRPW_PEND_MAX));
        doPop = pop && (count != 3'h0);
        next_wrPtr = doPush ? wrPtr + 2'h1 : wrPtr;
        next_rdPtr = doPop ? rdPtr + 2'h1 : rdPtr;
        next_count = count + {2'h0, doPush} - {2'h0, doPop};
        if (flush) begin
            next_wrPtr = 2'h0;
            next_rdPtr = 2'h0;
            next_count = 3'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr <= 2'h0;
            rdPtr <= 2'h0;
            count <= 3'h0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // Storage and registered head read
    always_ff @(posedge sys_clk) begin
        if (doPush) begin
            mem[wrPtr] <= pushData;
        end
        headData <= (next_count == 3'h0) ? '0 :
            ((doPush && next_count == 3'h1) ? pushData : mem[next_rdPtr]);
    end

    assign notEmpty = (count != 3'h0);
endmodule // brpw_fault_queue

//--- rtl/brpw_pkg.sv
package brpw_pkg;
    localparam logic [7:0] BRPW_OFS_FAULT_LO = 8'h38;
    localparam logic [7:0] BRPW_OFS_FAULT_HI = 8'h3C;
    localparam logic [7:0] BRPW_OFS_INT_SET = 8'h80;
    localparam logic [7:0] BRPW_OFS_INT_CLR = 8'h84;
    localparam int BRPW_BIT_PWFAULT = 8;
    localparam int BRPW_BIT_REQUEST_PACKET_EVENT = 4;
    localparam int BRPW_BIT_BUSRST = 17;
    localparam int BRPW_PEND_MAX = 4;
    localparam logic [31:0] BRPW_INT_RESET = 32'h0000_0000;
    localparam logic [5:0] BRPW_NODE_UNSET = 6'h3F;
    localparam logic [3:0] BRPW_RESP_COMPLETE = 4'h0;
    localparam logic [3:0] BRPW_RESP_DATA_ERR = 4'h5;
    localparam logic [3:0] BRPW_ACK_COMPLETE = 4'h1;
    localparam logic [3:0] BRPW_ACK_PENDING = 4'h2;
    localparam logic [3:0] BRPW_ACK_BUSY = 4'h4;
    localparam logic [3:0] BRPW_ACK_DATA_ERR = 4'hD;
    localparam logic [4:0] BRPW_EVT_MISSING_ACK = 5'h03;
    localparam logic [4:0] BRPW_EVT_FLUSHED = 5'h0F;
    localparam logic [4:0] BRPW_EVT_BUS_RESET = 5'h09;
    // Fault entry: source node id 16 bits, offset 48 bits
    localparam int BRPW_FAULT_W = 64;
    typedef enum logic [1:0] {
        BRPW_AT_IDLE = 2'b00,
        BRPW_AT_FLUSH = 2'b01,
        BRPW_AT_DRAIN = 2'b11
    } brpw_at_e;
endpackage

//--- rtl/brpw_resp_retry.sv
`timescale 1ns/10ps
// Physical read response code and retry decision
module brpw_resp_retry
    import brpw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic readDone,
    input wire logic readHostErr,
    input wire logic ackValid,
    input wire logic [3:0] ackCode,
    input wire logic retryHostErr,
    input wire logic discard,
    output logic respSend,
    output logic [3:0] respCode,
    output logic respRetired
);
    logic busy, next_busy, next_respSend, next_respRetired;
    logic [3:0] next_respCode;

    always_comb begin
        next_busy = busy;
        next_respSend = 1'b0;
        next_respRetired = 1'b0;
        next_respCode = respCode;
        if (discard) begin
            next_busy = 1'b0;
        end else if (readDone) begin
            next_busy = 1'b1;
            next_respSend = 1'b1;
            next_respCode = readHostErr ? BRPW_RESP_DATA_ERR : BRPW_RESP_COMPLETE;
        end else if (busy && ackValid) begin
            if (ackCode == BRPW_ACK_BUSY || ackCode == BRPW_ACK_DATA_ERR) begin
                next_respSend = 1'b1;
                if (retryHostErr) begin
                    next_respCode = BRPW_RESP_DATA_ERR;
                end
            end else begin
                next_busy = 1'b0;
                next_respRetired = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
            respSend <= 1'b0;
            respRetired <= 1'b0;
            respCode <= BRPW_RESP_COMPLETE;
        end else begin
            busy <= next_busy;
            respSend <= next_respSend;
            respRetired <= next_respRetired;
            respCode <= next_respCode;
        end
    end
endmodule // brpw_resp_retry

//--- tb/brpw_core_assertions.sv
`timescale 1ns/10ps
// Timing relations between the core's requests and its answers
module brpw_core_assertions
    import brpw_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic physReadDone,
    input wire logic physReadHostErr,
    input wire logic respAckValid,
    input wire logic [3:0] respAckCode,
    input wire logic retryHostErr,
    input wire logic respSend,
    input wire logic [3:0] respCode,
    input wire logic writeReq,
    input wire logic writeAckValid,
    input wire logic [3:0] writeAckCode,
    input wire logic busResetDetect,
    input wire logic pendingDiscard,
    input wire logic atHalt,
    input wire logic arReqActive,
    input wire logic rxFifoSpace,
    input wire logic hostBufSpace,
    input wire logic brPktWrite,
    input wire logic [4:0] brPktEvent,
    input wire logic isoHold
);
    logic retryAck;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // Requester asked for a resend of the last response
    assign retryAck = respAckValid && (respAckCode == BRPW_ACK_BUSY
        || respAckCode == BRPW_ACK_DATA_ERR);

    a_resp_host_err: assert property (
        physReadDone && physReadHostErr |=> respSend && respCode == BRPW_RESP_DATA_ERR)
        else $error("failed host read not answered with data error");
    a_retry_same: assert property (
        retryAck && !retryHostErr |=> respSend && $stable(respCode))
        else $error("underrun retry did not resend the same response");
    a_retry_err: assert property (
        retryAck && retryHostErr |=> respSend && respCode == BRPW_RESP_DATA_ERR)
        else $error("host error retry did not send data error");
    a_write_ack: assert property (writeReq |=> writeAckValid)
        else $error("write request not acknowledged next cycle");
    a_halt_reset: assert property (busResetDetect |=> atHalt)
        else $error("async transmit not halted after bus reset");
    a_discard_reset: assert property (busResetDetect |=> pendingDiscard)
        else $error("pending requests not discarded after bus reset");
    a_pkt_code: assert property (brPktWrite |-> brPktEvent == BRPW_EVT_BUS_RESET)
        else $error("bus reset packet carries wrong event");
    a_pkt_space: assert property (
        brPktWrite |-> $past(rxFifoSpace && hostBufSpace && arReqActive))
        else $error("bus reset packet written without space or active context");
    a_iso_free: assert property (!isoHold)
        else $error("isochronous contexts held");

    c_err_resp: cover property (respSend && respCode == BRPW_RESP_DATA_ERR);
    c_ack_pend: cover property (writeAckValid && writeAckCode == BRPW_ACK_PENDING);
    c_br_pkt: cover property (brPktWrite);
endmodule // brpw_core_assertions

bind brpw_core brpw_core_assertions u_chk (.sys_clk, .nrst, .physReadDone, .physReadHostErr,
    .respAckValid, .respAckCode, .retryHostErr, .respSend, .respCode, .writeReq,
    .writeAckValid, .writeAckCode, .busResetDetect, .pendingDiscard, .atHalt, .arReqActive,
    .rxFifoSpace, .hostBufSpace, .brPktWrite, .brPktEvent, .isoHold);

//--- tb/brpw_host_model.sv
`timescale 1ns/10ps
// Host memory side: finishes or fails one posted write per request
module brpw_host_model (
    input wire logic sys_clk,
    input wire logic go,
    input wire logic fail,
    input wire logic [15:0] node,
    input wire logic [47:0] off,
    output logic postDone,
    output logic postFail,
    output logic [15:0] postSrcNode,
    output logic [47:0] postOffset
);
    int waitN;

    // Prompt or slow answer; address lines show garbage when released
    initial begin
        postDone = 1'h0;
        postFail = 1'h0;
        postSrcNode = 16'h0;
        postOffset = 48'h0;
        forever begin
            @(posedge sys_clk);
            if (go === 1'h1) begin
                waitN = $urandom_range(2, 0);
                repeat (waitN + 1) @(negedge sys_clk);
                postDone = !fail;
                postFail = fail;
                postSrcNode = node;
                postOffset = off;
                @(negedge sys_clk);
                postDone = 1'h0;
                postFail = 1'h0;
                postSrcNode = ~node;
                postOffset = ~off;
            end
        end
    end
endmodule // brpw_host_model

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import brpw_pkg::*;
    logic sys_clk = 0, nrst = 0, regWrite = 0, regRead = 0, rdLast = 0;
    logic physReadDone = 0, physReadHostErr = 0, respAckValid = 0, retryHostErr = 0;
    logic writeReq = 0, writePostable = 0, busResetDetect = 0, atSentAwaitAck = 0;
    logic atQueued = 0, arReqActive = 0, rxFifoSpace = 0, hostBufSpace = 0;
    logic rqPacketDelivered = 0, pGo = 0, pFail = 0, rxPacketSeen = 0;
    logic [7:0] regAddr = 0, newGeneration = 0, brPktGeneration, gPrev;
    logic [31:0] regWdata = 0, regRdata;
    logic [3:0] respAckCode = 0, respCode, writeAckCode;
    logic [1:0] atRun = 0, atQuiet = 0, atActive;
    logic [15:0] pNode = 0, postSrcNode, nd [2];
    logic [47:0] pOff = 0, postOffset, of [2];
    logic [4:0] atStatusCode, brPktEvent;
    logic respSend, respRetired, writeAckValid, postDone, postFail, pendingDiscard;
    logic atHalt, atFlush, atStatusValid, brPktWrite, isoHold;
    logic [47:0] evq [$];
    int n_mismatch = 0, cmp_count = 0;

    brpw_core DUT (.sys_clk, .nrst, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
        .physReadDone, .physReadHostErr, .respAckValid, .respAckCode, .retryHostErr,
        .respSend, .respCode, .respRetired, .writeReq, .writePostable, .writeAckValid,
        .writeAckCode, .postDone, .postFail, .postSrcNode, .postOffset, .pendingDiscard,
        .busResetDetect, .newGeneration, .atSentAwaitAck, .atQueued, .atRun, .atQuiet,
        .atHalt, .atFlush, .atStatusValid, .atStatusCode, .atActive, .arReqActive,
        .rxFifoSpace, .hostBufSpace, .rxPacketSeen, .rqPacketDelivered, .brPktWrite,
        .brPktEvent, .brPktGeneration, .isoHold);
    brpw_host_model host_mdl (.sys_clk, .go(pGo), .fail(pFail), .node(pNode), .off(pOff),
        .postDone, .postFail, .postSrcNode, .postOffset);

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(string nm, logic [47:0] got, logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic ex(logic [2:0] k, logic [44:0] v);
        evq.push_back({k, v});
    endtask
    task automatic see(logic [2:0] k, logic [44:0] v);
        check("output", {k, v}, evq.size() ? evq.pop_front() : 'x);
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        cyc(1);
        s = 1'h0;
        cyc(1);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        regAddr = a;
        regWdata = d;
        pulse(regWrite);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        regAddr = a;
        ex(3'h7, 45'(e));
        pulse(regRead);
    endtask
    task automatic ack(logic [3:0] c, logic h, logic [2:0] k, logic [44:0] v);
        respAckCode = c;
        retryHostErr = h;
        ex(k, v);
        pulse(respAckValid);
    endtask
    task automatic wq(logic [3:0] c);
        ex(3'h3, 45'(c));
        pulse(writeReq);
    endtask
    task automatic host(logic f, logic [15:0] n, logic [47:0] o);
        pFail = f;
        pNode = n;
        pOff = o;
        pulse(pGo);
        cyc(4);
    endtask

    // Clock
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Hang guard
    initial begin
        repeat (4000) @(posedge sys_clk);
        n_mismatch++;
        close_out();
    end
    // Compares each result pulse or read data with the oldest note
    always @(posedge sys_clk) begin
        if (nrst === 1'h1) begin
            if (rdLast === 1'h1) see(3'h7, 45'(regRdata));
            if (respSend === 1'h1) see(3'h1, 45'(respCode));
            if (respRetired === 1'h1) see(3'h2, 45'h0);
            if (writeAckValid === 1'h1) see(3'h3, 45'(writeAckCode));
            if (brPktWrite === 1'h1) see(3'h4, 45'({brPktEvent, brPktGeneration}));
            if (pendingDiscard === 1'h1) see(3'h5, 45'h0);
            if (atStatusValid === 1'h1) see(3'h6, 45'(atStatusCode));
        end
        rdLast <= regRead;
    end
    // Main sequence
    initial begin
        void'($urandom(62198));
        cyc(6);
        nrst = 1'h1;
        cyc(1);
        rd(BRPW_OFS_INT_SET, BRPW_INT_RESET);
        rd(8'h40, 32'h0);
        ex(3'h1, 45'(BRPW_RESP_COMPLETE));
        pulse(physReadDone);
        ack(BRPW_ACK_BUSY, 1'h0, 3'h1, 45'(BRPW_RESP_COMPLETE));
        ack(BRPW_ACK_DATA_ERR, 1'h1, 3'h1, 45'(BRPW_RESP_DATA_ERR));
        ack(BRPW_ACK_COMPLETE, 1'h0, 3'h2, 45'h0);
        physReadHostErr = 1'h1;
        ex(3'h1, 45'(BRPW_RESP_DATA_ERR));
        pulse(physReadDone);
        physReadHostErr = 1'h0;
        ack(BRPW_ACK_COMPLETE, 1'h0, 3'h2, 45'h0);
        writePostable = 1'h1;
        repeat (BRPW_PEND_MAX) wq(BRPW_ACK_COMPLETE);
        wq(BRPW_ACK_PENDING);
        foreach (nd[i]) begin
            nd[i] = 16'($urandom);
            of[i] = 48'({$urandom, $urandom});
            host(1'h1, nd[i], of[i]);
        end
        wq(BRPW_ACK_PENDING);
        foreach (nd[i]) begin
            rd(BRPW_OFS_INT_SET, 32'h100);
            rd(BRPW_OFS_FAULT_LO, of[i][31:0]);
            rd(BRPW_OFS_FAULT_HI, {nd[i], of[i][47:32]});
            wr(BRPW_OFS_INT_CLR, 32'h100);
        end
        rd(BRPW_OFS_INT_SET, BRPW_INT_RESET);
        wq(BRPW_ACK_COMPLETE);
        wq(BRPW_ACK_COMPLETE);
        wq(BRPW_ACK_PENDING);
        host(1'h0, nd[0], of[0]);
        wq(BRPW_ACK_COMPLETE);
        arReqActive = 1'h1;
        hostBufSpace = 1'h1;
        atRun = 2'h3;
        atQuiet = 2'h1;
        atSentAwaitAck = 1'h1;
        atQueued = 1'h1;
        newGeneration = 8'($urandom);
        ex(3'h5, 45'h0);
        ex(3'h6, 45'(BRPW_EVT_MISSING_ACK));
        ex(3'h6, 45'(BRPW_EVT_FLUSHED));
        pulse(busResetDetect);
        atSentAwaitAck = 1'h0;
        cyc(1);
        atQueued = 1'h0;
        cyc(3);
        rd(BRPW_OFS_INT_SET, 32'h20000);
        check("atActive", atActive, 2'h2);
        check("atFlush", atFlush, 1'h1);
        newGeneration = 8'($urandom);
        ex(3'h5, 45'h0);
        pulse(busResetDetect);
        gPrev = newGeneration;
        pulse(rxPacketSeen);
        newGeneration = 8'($urandom);
        ex(3'h5, 45'h0);
        pulse(busResetDetect);
        ex(3'h4, 45'({BRPW_EVT_BUS_RESET, gPrev}));
        ex(3'h4, 45'({BRPW_EVT_BUS_RESET, newGeneration}));
        rxFifoSpace = 1'h1;
        cyc(4);
        rd(BRPW_OFS_INT_SET, 32'h20010);
        wr(BRPW_OFS_INT_CLR, 32'h10);
        pulse(rqPacketDelivered);
        rd(BRPW_OFS_INT_SET, 32'h20010);
        atRun = 2'h0;
        atQuiet = 2'h3;
        cyc(2);
        check("atActive", atActive, 2'h0);
        wr(BRPW_OFS_INT_CLR, 32'h20000);
        cyc(1);
        check("atFlush", atFlush, 1'h0);
        check("notes left", evq.size(), 48'h0);
        close_out();
    end
endmodule // testbench
